/* File: fts_fan_tach_top.sv */
// fan tach mode select, spin-up end control, test register and xor tree
`include "fts_defs.svh"
`default_nettype none
// Function
// - each tach input has four measurement modes at low pwm frequency
// - high pwm frequency forces mode 0 on every tach input
// - bits 5:4 set inputs three and four, 3:2 input two, 1:0 input one
// - every reading assumes two tach pulses per revolution
// - mode 00 counts plainly, may read falsely when too slow
// - mode 01 counts plainly, reads FFFFh when too slow
// - modes 10 and 11 compensate pwm, extend range, read FFFFh when slow
// - lowest detectable speed follows pwm frequency, per mode pair
// - mode register stays writable under lock, resets to 00h
// - with start clear, defaults of mode and spin-up registers act
// - spin-up mode bits 2:0 belong to pwm outputs three, two, one
// - bit clear ends spin-up only when programmed time elapses
// - bit set ends spin-up at fast tach reading or time, first wins
// - spin-up mode register ignores writes once lock is set
// - reads of undefined addresses return 00h
// - writes to undefined addresses change nothing, raise no error
// - setting test bit at 6Fh enters xor tree test mode
// - xor tree leaves out bus data and clock pins, order free
// - test bit is bit 0; writing zero leaves test mode
// - test register ignores writes once lock is set
module fts_fan_tach_top (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   input  wire logic        cfg_lock,
   input  wire logic        cfg_start,
   input  wire logic        pwm_high_freq,
   input  wire logic [2:0]  pwm_freq_sel,
   input  wire logic        fan_pulse_in_one,
   input  wire logic        fan_pulse_in_two,
   input  wire logic        fan_pulse_in_three,
   input  wire logic        fan_pulse_in_four,
   input  wire logic [2:0]  spinup_begin,
   input  wire logic [15:0] spinup_ticks_one,
   input  wire logic [15:0] spinup_ticks_two,
   input  wire logic [15:0] spinup_ticks_three,
   input  wire logic [15:0] tach_min_one,
   input  wire logic [15:0] tach_min_two,
   input  wire logic [15:0] tach_min_three,
   input  wire logic [15:0] tach_min_four,
   output logic      [15:0] tach_count_one,
   output logic      [15:0] tach_count_two,
   output logic      [15:0] tach_count_three,
   output logic      [15:0] tach_count_four,
   output logic      [2:0]  spinup_active,
   output logic      [2:0]  pwm_comp_req,
   output logic             xor_tree_enable,
   output logic             xor_tree_out
);
   import fts_pkg::*;

   // ***************************************
   // helpers
   // ***************************************
   // count ceiling from lowest speed
   function automatic logic [15:0] speed_limit(input logic ext, input logic [2:0] sel);
      logic [15:0] l;
      l = 16'h0000;
      unique case (sel)
         3'h0: l = ext ? `FTS_LIM(210) : `FTS_LIM(841);
         3'h1: l = ext ? `FTS_LIM(315) : `FTS_LIM(1262);
         3'h2: l = ext ? `FTS_LIM(420) : `FTS_LIM(1944);
         3'h3: l = ext ? `FTS_LIM(420) : `FTS_LIM(2523);
         3'h4: l = ext ? `FTS_LIM(420) : `FTS_LIM(3205);
         3'h5: l = ext ? `FTS_LIM(420) : `FTS_LIM(3953);
         3'h6: l = ext ? `FTS_LIM(420) : `FTS_LIM(5156);
         3'h7: l = ext ? `FTS_LIM(420) : `FTS_LIM(7906);
      endcase
      return l;
   endfunction

   function automatic fts_mode_t field_of(input logic [5:0] m, input int ch);
      fts_mode_t f;
      f = 2'b00;
      unique case (ch)
         0:       f = m[`FTS_T1_LSB +: 2];
         1:       f = m[`FTS_T2_LSB +: 2];
         default: f = m[`FTS_T34_LSB +: 2];
      endcase
      return f;
   endfunction

   // ***************************************
   // pin synchronisers and timebase
   // ***************************************
   logic [3:0]  pulse_s;
   logic [11:0] div_r, div_nxt;
   logic        tick_r, tick_nxt;

   fts_sync #(.W(4)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({fan_pulse_in_four, fan_pulse_in_three, fan_pulse_in_two, fan_pulse_in_one}),
      .q     (pulse_s)
   );

   always_comb begin
      tick_nxt = (div_r == 12'(`FTS_TICK_DIV - 1));
      div_nxt  = tick_nxt ? 12'h000 : div_r + 12'h001;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r  <= 12'h000;
         tick_r <= 1'b0;
      end else begin
         div_r  <= div_nxt;
         tick_r <= tick_nxt;
      end
   end

   // ***************************************
   // registers
   // ***************************************
   logic [5:0] mode_r, mode_nxt, mode_eff;
   logic [2:0] spin_r, spin_nxt, spin_eff;
   logic       xen_r, xen_nxt;
   logic [7:0] rdata_nxt;

   always_comb begin
      mode_nxt  = mode_r;
      spin_nxt  = spin_r;
      xen_nxt   = xen_r;
      rdata_nxt = reg_rdata;
      if (reg_wr) begin
         unique case (reg_addr)
            `FTS_ADDR_MODE: mode_nxt = reg_wdata[5:0];
            `FTS_ADDR_SPIN: if (!cfg_lock) spin_nxt = reg_wdata[2:0];
            `FTS_ADDR_TEST: if (!cfg_lock) xen_nxt = reg_wdata[`FTS_XEN_BIT];
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `FTS_ADDR_MODE: rdata_nxt = {2'b00, mode_r};
            `FTS_ADDR_SPIN: rdata_nxt = {5'b00000, spin_r};
            `FTS_ADDR_TEST: rdata_nxt = {7'h00, xen_r};
            default:        rdata_nxt = `FTS_READ_NONE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r    <= `FTS_MODE_RST;
         spin_r    <= `FTS_SPIN_RST;
         xen_r     <= `FTS_TEST_RST;
         reg_rdata <= 8'h00;
      end else begin
         mode_r    <= mode_nxt;
         spin_r    <= spin_nxt;
         xen_r     <= xen_nxt;
         reg_rdata <= rdata_nxt;
      end
   end

   assign mode_eff = (!cfg_start || pwm_high_freq) ? `FTS_MODE_RST : mode_r;
   assign spin_eff = cfg_start ? spin_r : `FTS_SPIN_RST;

   // ***************************************
   // tach channels
   // ***************************************
   logic [15:0] cnt_w [4];
   logic [3:0]  comp_w;
   fts_mode_t   chm [4];

   generate
      for (genvar i = 0; i < 4; i++) begin : g_ch
         assign chm[i] = field_of(mode_eff, i);
         fts_tach_chan u_ch (
            .clk     (clk),
            .rst_n   (rst_n),
            .tick    (tick_r),
            .pulse   (pulse_s[i]),
            .mode    (chm[i]),
            .limit   (speed_limit(chm[i][1], pwm_freq_sel)),
            .count_r (cnt_w[i]),
            .comp_r  (comp_w[i])
         );
      end
   endgenerate

   assign tach_count_one   = cnt_w[0];
   assign tach_count_two   = cnt_w[1];
   assign tach_count_three = cnt_w[2];
   assign tach_count_four  = cnt_w[3];

   // ***************************************
   // spin-up end control
   // ***************************************
   logic [2:0]  busy_nxt, fast, comp_nxt;
   logic [15:0] su_r [3];
   logic [15:0] su_nxt [3];
   logic [15:0] dur [3];
   logic        xor_nxt;

   assign dur[0] = spinup_ticks_one;
   assign dur[1] = spinup_ticks_two;
   assign dur[2] = spinup_ticks_three;
   assign fast[0] = cnt_w[0] < tach_min_one;
   assign fast[1] = cnt_w[1] < tach_min_two;
   assign fast[2] = (cnt_w[2] < tach_min_three) || (cnt_w[3] < tach_min_four);

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         busy_nxt[i] = spinup_active[i];
         su_nxt[i]   = su_r[i];
         if (spinup_begin[i]) begin
            busy_nxt[i] = 1'b1;
            su_nxt[i]   = 16'h0000;
         end else if (spinup_active[i]) begin
            if (tick_r) su_nxt[i] = su_r[i] + 16'h0001;
            if (su_r[i] >= dur[i] || (spin_eff[i] && fast[i])) busy_nxt[i] = 1'b0;
         end
      end
      // output three serves inputs three and four
      comp_nxt = {comp_w[2] | comp_w[3], comp_w[1], comp_w[0]};
      // only block pins, no bus pins
      xor_nxt = ^{pulse_s, spinup_begin, cfg_lock, cfg_start, pwm_high_freq, pwm_freq_sel};
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         spinup_active   <= 3'h0;
         su_r            <= '{default: 16'h0000};
         pwm_comp_req    <= 3'h0;
         xor_tree_enable <= 1'b0;
         xor_tree_out    <= 1'b0;
      end else begin
         spinup_active   <= busy_nxt;
         su_r            <= su_nxt;
         pwm_comp_req    <= comp_nxt;
         xor_tree_enable <= xen_r;
         xor_tree_out    <= xen_r & xor_nxt;
      end
   end

   // ***************************************
   // checks
   // ***************************************
   a_mode_unlocked: assert property (@(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == 8'h74) |=> (mode_r == $past(reg_wdata[5:0])))
      else $error("mode write lost");

   a_spin_locked: assert property (@(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == 8'h75 && cfg_lock) |=> $stable(spin_r))
      else $error("locked spin-up write took effect");

   a_test_locked: assert property (@(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == 8'h6F && cfg_lock) |=> $stable(xen_r))
      else $error("locked test write took effect");

   a_xen_enter: assert property (@(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == 8'h6F && !cfg_lock) |=> ##1
      (xor_tree_enable == $past(reg_wdata[0], 2)))
      else $error("test mode not following write");

   a_undef_read: assert property (@(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr != 8'h6F && reg_addr != 8'h74 && reg_addr != 8'h75)
      |=> (reg_rdata == 8'h00))
      else $error("undefined read not zero");

   a_undef_write: assert property (@(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr != 8'h6F && reg_addr != 8'h74 && reg_addr != 8'h75)
      |=> ($stable(mode_r) && $stable(spin_r) && $stable(xen_r)))
      else $error("undefined write changed state");

   a_start_default: assert property (@(posedge clk) disable iff (!rst_n)
      !cfg_start |-> (mode_eff == 6'h00 && spin_eff == 3'h7))
      else $error("defaults not used before start");

   a_high_freq: assert property (@(posedge clk) disable iff (!rst_n)
      pwm_high_freq |-> (chm[0] == 2'b00 && chm[1] == 2'b00 && chm[2] == 2'b00))
      else $error("high range not forced to mode 0");

   a_pair_mode: assert property (@(posedge clk) disable iff (!rst_n)
      (chm[2] == chm[3]) && (chm[2] == mode_eff[5:4]) && (chm[0] == mode_eff[1:0]))
      else $error("mode fields mismatched");

   a_spin_early: assert property (@(posedge clk) disable iff (!rst_n)
      (spinup_active[0] && !spinup_begin[0] && spin_eff[0] && fast[0])
      |=> !spinup_active[0])
      else $error("spin-up not ended early");

   a_spin_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (spinup_active[0] && !spinup_begin[0] && !spin_eff[0] && su_r[0] < spinup_ticks_one)
      |=> spinup_active[0])
      else $error("spin-up ended before time");
endmodule
`default_nettype wire

/* File: fts_defs.svh */
// offsets, fields, reset values and timing counts of the fan tach block
`ifndef FTS_DEFS_SVH
`define FTS_DEFS_SVH

`define FTS_ADDR_TEST    8'h6F
`define FTS_ADDR_MODE    8'h74
`define FTS_ADDR_SPIN    8'h75

`define FTS_XEN_BIT      0
`define FTS_T1_LSB       0
`define FTS_T2_LSB       2
`define FTS_T34_LSB      4

`define FTS_MODE_RST     6'h00
`define FTS_SPIN_RST     3'h7
`define FTS_TEST_RST     1'b0
`define FTS_READ_NONE    8'h00

`define FTS_CLK_HZ       250000000
`define FTS_TICK_HZ      90000
`define FTS_TICK_DIV     (`FTS_CLK_HZ / `FTS_TICK_HZ)
`define FTS_REV_PULSES   2
`define FTS_COUNT_BAD    16'hFFFF
`define FTS_LIM(rpm)     16'((`FTS_TICK_HZ * 60) / (rpm))

`endif

/* File: fts_pkg.sv */
// types shared by the fan tach block
`default_nettype none
package fts_pkg;
   typedef enum logic [1:0] {
      FTS_WAIT = 2'b01,
      FTS_MEAS = 2'b10
   } fts_tach_st_t;
   typedef logic [1:0] fts_mode_t;
endpackage
`default_nettype wire

/* File: fts_sync.sv */
// two-flop synchroniser for pin inputs
`default_nettype none
module fts_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_n) begin
      // reset to the idle-high pin level, no false edge after reset
      if (!rst_n) begin
         meta_r <= '1;
         q      <= '1;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule
`default_nettype wire

/* File: fts_tach_chan.sv */
// one tach input: period of one fan revolution in timebase ticks
`include "fts_defs.svh"
`default_nettype none
module fts_tach_chan (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              tick,
   input  wire logic              pulse,
   input  wire fts_pkg::fts_mode_t mode,
   input  wire logic [15:0]       limit,
   output logic      [15:0]       count_r,
   output logic                   comp_r
);
   import fts_pkg::*;

   fts_tach_st_t st_r, st_nxt;
   logic [15:0]  cnt_r, cnt_nxt, count_nxt;
   logic         ed_r, ed_nxt, prev_r, comp_nxt, rise;

   assign rise = pulse & ~prev_r;

   always_comb begin
      st_nxt    = st_r;
      cnt_nxt   = cnt_r;
      ed_nxt    = ed_r;
      count_nxt = count_r;
      unique case (st_r)
         FTS_WAIT: begin
            if (rise) begin
               st_nxt  = FTS_MEAS;
               cnt_nxt = 16'h0000;
               ed_nxt  = 1'b0;
            end
         end
         FTS_MEAS: begin
            if (tick) begin
               cnt_nxt = cnt_r + 16'h0001;
            end
            if (rise) begin
               ed_nxt = ~ed_r;
               if (ed_r) begin
                  count_nxt = cnt_r;
                  cnt_nxt   = 16'h0000;
               end
            end else if (mode != 2'b00 && cnt_r >= limit) begin
               count_nxt = `FTS_COUNT_BAD;
               st_nxt    = FTS_WAIT;
            end
            // mode 0 just wraps, reading may be false
         end
         default: st_nxt = FTS_WAIT;
      endcase
      // drive hold, whole period or second half only
      comp_nxt = (st_r == FTS_MEAS) && (mode == 2'b10 || (mode == 2'b11 && ed_r));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r    <= FTS_WAIT;
         cnt_r   <= 16'h0000;
         ed_r    <= 1'b0;
         prev_r  <= 1'b1;
         count_r <= 16'h0000;
         comp_r  <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         cnt_r   <= cnt_nxt;
         ed_r    <= ed_nxt;
         prev_r  <= pulse;
         count_r <= count_nxt;
         comp_r  <= comp_nxt;
      end
   end

   a_slow_invalid: assert property (@(posedge clk) disable iff (!rst_n)
      (st_r == FTS_MEAS && !rise && mode != 2'b00 && cnt_r >= limit)
      |=> (count_r == 16'hFFFF && st_r == FTS_WAIT))
      else $error("slow fan did not read all ones");

   a_rev_result: assert property (@(posedge clk) disable iff (!rst_n)
      (st_r == FTS_MEAS && rise && ed_r) |=> (count_r == $past(cnt_r)))
      else $error("revolution count not reported");
endmodule
`default_nettype wire

/* File: fts_fan_model.sv */
// behavioural fans giving tach pulses to the four pins
`default_nettype none
module fts_fan_model (
   input  wire logic        clk,
   input  wire logic        run,
   input  wire logic        idle_lvl,
   input  wire logic [31:0] half_cyc,
   output logic             fan_pulse_in_one,
   output logic             fan_pulse_in_two,
   output logic             fan_pulse_in_three,
   output logic             fan_pulse_in_four
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] cnt_r = 32'h0;
   logic        lvl_r = 1'b1;
   always @(posedge clk) begin
      if (!run) begin
         cnt_r <= 32'h0;
         lvl_r <= 1'b1;
      end else if (cnt_r + 32'h1 >= half_cyc) begin
         cnt_r <= 32'h0;
         lvl_r <= ~lvl_r;
      end else begin
         cnt_r <= cnt_r + 32'h1;
      end
   end
   // three and four share one drive
   assign fan_pulse_in_one   = run ? lvl_r : idle_lvl;
   assign fan_pulse_in_two   = lvl_r;
   assign fan_pulse_in_three = lvl_r;
   assign fan_pulse_in_four  = lvl_r;
endmodule
`default_nettype wire

/* File: test_fan_tach_mode_and_spinup.sv */
// self-checking bench of the fan tach block
`include "fts_defs.svh"
`default_nettype none
module test_fan_tach_mode_and_spinup;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = `FTS_TICK_DIV;
   typedef struct packed {
      logic       w;
      logic       lk;
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } fts_row_t;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_wdata = 8'h00;
   logic [7:0]  reg_rdata;
   logic        cfg_lock = 1'b0;
   logic        cfg_start = 1'b0;
   logic        pwm_high_freq = 1'b0;
   logic [2:0]  pwm_freq_sel = 3'h0;
   logic        fan_pulse_in_one, fan_pulse_in_two, fan_pulse_in_three, fan_pulse_in_four;
   logic [2:0]  spinup_begin = 3'h0;
   logic [15:0] spin_tk = 16'h0003;
   logic [15:0] t_min = 16'hFFFF;
   logic [15:0] cnt1, cnt2, cnt3, cnt4;
   logic [2:0]  spinup_active, pwm_comp_req;
   logic        xor_tree_enable, xor_tree_out;
   logic        fan_run = 1'b0;
   logic        idle = 1'b1;
   logic        b;
   int          err_count = 0;
   int          checked = 0;
   int          cyc = 0;
   int          n;
   fts_row_t    rows [13] = '{
      '{1'b1, 1'b0, 8'h74, 8'h3F, 8'h3F},
      '{1'b1, 1'b0, 8'h74, 8'hFF, 8'h3F},
      '{1'b1, 1'b1, 8'h74, 8'h1B, 8'h1B},
      '{1'b1, 1'b0, 8'h75, 8'h05, 8'h05},
      '{1'b1, 1'b0, 8'h75, 8'hFA, 8'h02},
      '{1'b1, 1'b1, 8'h75, 8'h07, 8'h02},
      '{1'b1, 1'b0, 8'h6F, 8'h01, 8'h01},
      '{1'b1, 1'b1, 8'h6F, 8'h00, 8'h01},
      '{1'b1, 1'b0, 8'h6F, 8'hFE, 8'h00},
      '{1'b1, 1'b0, 8'h70, 8'h5A, 8'h00},
      '{1'b1, 1'b0, 8'h00, 8'hFF, 8'h00},
      '{1'b0, 1'b0, 8'h74, 8'h00, 8'h1B},
      '{1'b0, 1'b0, 8'h75, 8'h00, 8'h02}
   };

   fts_fan_tach_top dut_u (
      .clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
      .cfg_lock, .cfg_start, .pwm_high_freq, .pwm_freq_sel,
      .fan_pulse_in_one, .fan_pulse_in_two, .fan_pulse_in_three, .fan_pulse_in_four,
      .spinup_begin, .spinup_ticks_one(spin_tk), .spinup_ticks_two(spin_tk),
      .spinup_ticks_three(spin_tk), .tach_min_one(t_min), .tach_min_two(t_min),
      .tach_min_three(t_min), .tach_min_four(t_min), .tach_count_one(cnt1),
      .tach_count_two(cnt2), .tach_count_three(cnt3), .tach_count_four(cnt4),
      .spinup_active, .pwm_comp_req, .xor_tree_enable, .xor_tree_out
   );
   fts_fan_model fan_u (
      .clk, .run(fan_run), .idle_lvl(idle), .half_cyc(32'(TK)),
      .fan_pulse_in_one, .fan_pulse_in_two, .fan_pulse_in_three, .fan_pulse_in_four
   );

   always #2 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         err_count++;
         $display("unexpected %0t run too long", $time);
         end_sim();
      end
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic fail(input string m);
      err_count++;
      $display("unexpected %0t %s", $time, m);
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) fail($sformatf("byte %h want %h", got, exp));
   endtask
   task automatic chk1(input logic got, input logic exp);
      checked++;
      if (got !== exp) fail($sformatf("bit %b want %b", got, exp));
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
      checked++;
      if ($isunknown(got) || got < lo || got > hi) fail($sformatf("value %h out of range", got));
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      @(negedge clk);
      chk8(reg_rdata, exp);
   endtask
   task automatic spin(output int k);
      @(negedge clk);
      spinup_begin = 3'h1;
      @(negedge clk);
      spinup_begin = 3'h0;
      chk1(spinup_active[0], 1'b1);
      k = 0;
      while (spinup_active[0] === 1'b1 && k < 5 * TK) begin
         @(negedge clk);
         k++;
      end
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
   endtask
   task automatic end_sim();
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ****************************************
   // sequence
   // ****************************************
   initial begin
      do_reset();
      rd(8'h74, 8'h00);
      rd(8'h75, 8'h07);
      rd(8'h6F, 8'h00);
      foreach (rows[i]) begin
         cfg_lock = rows[i].lk;
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      cfg_lock = 1'b0;
      chk1(xor_tree_out, 1'b0);
      wr(8'h6F, 8'h01);
      repeat (6) @(negedge clk);
      chk1(xor_tree_enable, 1'b1);
      b = xor_tree_out;
      idle = ~idle;
      repeat (6) @(negedge clk);
      chk1(xor_tree_out, ~b);
      wr(8'h6F, 8'h00);
      repeat (4) @(negedge clk);
      chk1(xor_tree_enable, 1'b0);
      chk1(xor_tree_out, 1'b0);
      wr(8'h74, 8'h08);
      cfg_start = 1'b1;
      fan_run = 1'b1;
      n = 0;
      while (cnt1 === 16'h0000 && n < 40000) begin
         @(negedge clk);
         n++;
      end
      chk16(cnt1, 16'h0003, 16'h0005);
      while (cnt4 === 16'h0000 && n < 40000) begin
         @(negedge clk);
         n++;
      end
      chk16(cnt2, 16'h0003, 16'h0005);
      chk16(cnt3, 16'h0003, 16'h0005);
      chk16(cnt4, 16'h0003, 16'h0005);
      chk1(pwm_comp_req[0], 1'b0);
      chk1(pwm_comp_req[1], 1'b1);
      pwm_high_freq = 1'b1;
      repeat (4) @(negedge clk);
      chk1(pwm_comp_req[1], 1'b0);
      pwm_high_freq = 1'b0;
      wr(8'h75, 8'h06);
      spin(n);
      chk16(16'(n), 16'(2 * TK), 16'(4 * TK + 8));
      wr(8'h75, 8'h07);
      spin(n);
      chk16(16'(n), 16'h0000, 16'h0008);
      wr(8'h75, 8'h06);
      cfg_start = 1'b0;
      spin(n);
      chk16(16'(n), 16'h0000, 16'h0008);
      chk1(pwm_comp_req[1], 1'b0);
      do_reset();
      rd(8'h74, 8'h00);
      rd(8'h75, 8'h07);
      end_sim();
   end
endmodule
`default_nettype wire
